// ==== pkg/fan_ctrl_pkg.sv ====
// =============================================================================
// fan control constants
package fan_ctrl_pkg;
    // command codes and reply marker
    localparam logic [7:0] CMD_FAILSAFE = 8'h19;
    localparam logic [7:0] CMD_GLITCH = 8'h1A;
    localparam logic [7:0] CMD_QUERY = 8'h1B;
    localparam logic [7:0] REPLY_BIT = 8'h40;
    // payload lengths
    localparam logic [7:0] LEN_FAILSAFE = 8'h02;
    localparam logic [7:0] LEN_GLITCH = 8'h04;
    localparam logic [7:0] LEN_QUERY = 8'h00;
    localparam logic [7:0] LEN_QUERY_REPLY = 8'h05;
    // fan count and mask width
    localparam int NUM_FANS = 4;
    // power scale: full power value and pwm steps per period
    localparam logic [7:0] FULL_POWER = 8'h64;
    localparam logic [6:0] PWM_STEPS = 7'h64;
    // reset values
    localparam logic [7:0] GLITCH_DEFAULT = 8'h01;
    // timing: one pwm step (1/100 of the 18 Hz period) and one eighth second
    localparam int CLK_MHZ = 125;
    localparam int STEP_TIME_PS = 552500000;
    // ps to ns first, so the product with CLK_MHZ stays within int range
    localparam int STEP_CYCLES = STEP_TIME_PS / 1000 * CLK_MHZ / 1000;
    localparam int TICK_TIME_MS_X8 = 1000;
    localparam int TICK_CYCLES = TICK_TIME_MS_X8 / 8 * 1000 * CLK_MHZ;
endpackage

// ==== logic/fan_failsafe_tach_control.sv ====
`timescale 1ns/1ns
module fan_failsafe_tach_control
    import fan_ctrl_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES,
    parameter int TICK_CYC = TICK_CYCLES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // decoded host command
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_type,
    input wire logic [7:0] i_cmd_len,
    input wire logic [3:0][7:0] i_cmd_data,
    // host fan power updates
    input wire logic [3:0] i_pwr_we,
    input wire logic [3:0][7:0] i_pwr_val,
    // boot-state store request
    input wire logic i_boot_store,
    // tachometer pins
    input wire logic [3:0] i_tach,
    // reply to host
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_type,
    output logic [7:0] o_rsp_len,
    output logic [4:0][7:0] o_rsp_data,
    // fan drive and tach events
    output logic [3:0] o_fan_on,
    output logic [3:0] o_tach_pulse,
    // status
    output logic [3:0][7:0] o_fan_power,
    output logic [3:0] o_fs_mask,
    output logic [3:0][7:0] o_glitch,
    output logic [3:0][7:0] o_boot_glitch
);

    // =========================================================================
    // state
    typedef struct packed {
        logic [16:0] step_pre;      // cycles within a pwm step
        logic [6:0] phase;          // pwm step 0..99
        logic [23:0] tick_pre;      // cycles within an eighth second
        logic [3:0][7:0] power;     // fan power 0..100
        logic [3:0] fs_mask;        // supervised fans
        logic [7:0] fs_timeout;     // programmed timeout
        logic [3:0][7:0] fs_cnt;    // countdown per fan
        logic [3:0][7:0] glitch;    // blanking delay per fan
        logic [3:0][7:0] boot_glitch; // saved boot copy
        logic [3:0][7:0] blank;     // blanking remaining
        logic [3:0] fan_on;         // pwm output
        logic [3:0] tach_s1;        // sync stage one
        logic [3:0] tach_s2;        // sync stage two
        logic [3:0] tach_s3;        // previous synced level
        logic [3:0] tach_pulse;     // accepted tach edge
        logic rsp_valid;            // reply strobe
        logic [7:0] rsp_type;       // reply type
        logic [7:0] rsp_len;        // reply length
        logic [4:0][7:0] rsp_data;  // reply payload
    } state_s;

    state_s st;
    state_s next_st;
    logic step_end; // last cycle of a pwm step
    logic tick_end; // last cycle of an eighth second
    logic is_fs;    // valid fail-safe command
    logic is_gl;    // valid glitch command
    logic is_qr;    // valid query command

    assign step_end = (st.step_pre == 17'(STEP_CYC - 1));
    assign tick_end = (st.tick_pre == 24'(TICK_CYC - 1));
    assign is_fs = i_cmd_valid && i_cmd_type == CMD_FAILSAFE && i_cmd_len == LEN_FAILSAFE;
    assign is_gl = i_cmd_valid && i_cmd_type == CMD_GLITCH && i_cmd_len == LEN_GLITCH;
    assign is_qr = i_cmd_valid && i_cmd_type == CMD_QUERY && i_cmd_len == LEN_QUERY;

    // =========================================================================
    // next-state logic
    always_comb
    begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        // pwm timebase, 100 steps per period
        next_st.step_pre = step_end ? 17'h00000 : st.step_pre + 17'h00001;
        if (step_end)
        begin
            next_st.phase = (st.phase == PWM_STEPS - 7'h01) ? 7'h00 : st.phase + 7'h01;
        end
        // eighth-second tick prescaler
        next_st.tick_pre = tick_end ? 24'h000000 : st.tick_pre + 24'h000001;
        // synchroniser chain and edge history
        next_st.tach_s1 = i_tach;
        next_st.tach_s2 = st.tach_s1;
        next_st.tach_s3 = st.tach_s2;
        for (int i = 0; i < NUM_FANS; i++)
        begin
            // pwm compare, 100 or more means always on
            next_st.fan_on[i] = ({1'b0, st.phase} < st.power[i]);
            // blanking counts down once per pwm step
            if (step_end && st.blank[i] != 8'h00)
            begin
                next_st.blank[i] = st.blank[i] - 8'h01;
            end
            // turn-on edge restarts blanking
            if (next_st.fan_on[i] && !st.fan_on[i])
            begin
                next_st.blank[i] = st.glitch[i];
            end
            // only edges seen while powered and not blanked count
            next_st.tach_pulse[i] = st.fan_on[i] && st.blank[i] == 8'h00
                && (st.tach_s2[i] != st.tach_s3[i]);
            // fail-safe countdown, expiry forces full power
            if (tick_end && st.fs_mask[i] && st.fs_cnt[i] != 8'h00)
            begin
                next_st.fs_cnt[i] = st.fs_cnt[i] - 8'h01;
                if (st.fs_cnt[i] == 8'h01)
                begin
                    next_st.power[i] = FULL_POWER;
                end
            end
            // host update wins over expiry and restarts countdown
            if (i_pwr_we[i])
            begin
                next_st.power[i] = i_pwr_val[i];
                next_st.fs_cnt[i] = st.fs_timeout;
            end
        end
        // fail-safe command: mask and timeout
        if (is_fs)
        begin
            next_st.fs_mask = i_cmd_data[0][3:0];
            next_st.fs_timeout = i_cmd_data[1];
            for (int i = 0; i < NUM_FANS; i++)
            begin
                next_st.fs_cnt[i] = i_cmd_data[1];
            end
        end
        // glitch command: four delays in fan order
        if (is_gl)
        begin
            next_st.glitch = i_cmd_data;
        end
        // boot-state store keeps the delays
        if (i_boot_store)
        begin
            next_st.boot_glitch = st.glitch;
        end
        // reply for each accepted command
        if (is_fs || is_gl || is_qr)
        begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_type = i_cmd_type | REPLY_BIT;
            next_st.rsp_len = is_qr ? LEN_QUERY_REPLY : 8'h00;
            next_st.rsp_data = '0;
            if (is_qr)
            begin
                next_st.rsp_data = {4'h0, st.fs_mask, st.power};
            end
        end
    end

    // =========================================================================
    // state register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
            st.glitch <= {NUM_FANS{GLITCH_DEFAULT}};
            st.boot_glitch <= {NUM_FANS{GLITCH_DEFAULT}};
        end
        else
        begin
            st <= next_st;
        end
    end

    // =========================================================================
    // outputs
    assign o_rsp_valid = st.rsp_valid;
    assign o_rsp_type = st.rsp_type;
    assign o_rsp_len = st.rsp_len;
    assign o_rsp_data = st.rsp_data;
    assign o_fan_on = st.fan_on;
    assign o_tach_pulse = st.tach_pulse;
    assign o_fan_power = st.power;
    assign o_fs_mask = st.fs_mask;
    assign o_glitch = st.glitch;
    assign o_boot_glitch = st.boot_glitch;

    // =========================================================================
    // checks
    AST_FS_MASK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_fs |=> o_fs_mask == $past(i_cmd_data[0][3:0]))
        else $error("fail-safe mask not taken");
    AST_FS_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_fs |=> st.fs_cnt[1] == $past(i_cmd_data[1])
        && st.fs_timeout == $past(i_cmd_data[1]))
        else $error("fail-safe timeout not loaded");
    // fan two is one of the three fans that expire in the bench
    AST_FORCE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick_end && st.fs_mask[1] && st.fs_cnt[1] == 8'h01 && !i_pwr_we[1]
        |=> o_fan_power[1] == FULL_POWER)
        else $error("expired fan not forced to full power");
    AST_FAN4: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_fs && i_cmd_data[0][3] |=> o_fs_mask[3])
        else $error("fourth fan bit dropped");
    // full power keeps the fan on through the whole period
    AST_PWM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_fan_power[2] >= FULL_POWER |=> o_fan_on[2] && st.phase < PWM_STEPS)
        else $error("pwm phase or full power output wrong");
    // zero power keeps the fan off
    AST_PWM_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_fan_power[0] == 8'h00 |=> !o_fan_on[0])
        else $error("fan on at zero power");
    // phase wraps after the last of the hundred steps
    AST_PWM_WRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        step_end && st.phase == PWM_STEPS - 7'h01 |=> st.phase == 7'h00)
        else $error("pwm phase did not wrap");
    // a zero delay count may let an edge through right away
    AST_BLANK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_fan_on[0]) |-> st.blank[0] == $past(st.glitch[0])
        ##1 (!o_tach_pulse[0] || $past(st.blank[0]) == 8'h00))
        else $error("tach not blanked after turn-on");
    AST_DEFAULT: assert property (@(posedge i_clk)
        !i_rst_n |=> o_glitch[3] == GLITCH_DEFAULT && o_boot_glitch[0] == GLITCH_DEFAULT)
        else $error("blanking delay default wrong");
    AST_GLITCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_gl |=> o_glitch == $past(i_cmd_data))
        else $error("glitch delays not set");
    AST_BOOT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_boot_store |=> o_boot_glitch == $past(o_glitch))
        else $error("boot copy of delays not saved");
    AST_QUERY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_qr |=> o_rsp_len == LEN_QUERY_REPLY && o_rsp_data[4][3:0] == $past(o_fs_mask)
        && o_rsp_data[1] == $past(o_fan_power[1]))
        else $error("query reply wrong");
    AST_REPLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (is_fs || is_gl) |=> o_rsp_valid && o_rsp_type == ($past(i_cmd_type) | REPLY_BIT)
        && o_rsp_len == 8'h00 ##1 !o_rsp_valid || $past(i_cmd_valid))
        else $error("reply type or length wrong");
    AST_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_pwr_we[2] && !is_fs |=> st.fs_cnt[2] == $past(st.fs_timeout))
        else $error("countdown not restarted on power update");

endmodule // fan_failsafe_tach_control

// ==== verification/fan_model.sv ====
`timescale 1ns/1ns
// ==========
// fan model: tach spins while powered, wanders when unpowered
module fan_model
(
    // clock
    input wire logic i_clk,
    // supply from the block
    input wire logic [3:0] i_fan_on,
    // tach lines to the block
    output logic [3:0] o_tach = 4'h0
);
    logic [1:0] div = 2'h0; // spin divider
    // tach edges, moved off the sampling edge
    always @(negedge i_clk)
    begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        for (int f = 0; f < 4; f++)
        begin
            if (i_fan_on[f] !== 1'b1)
                o_tach[f] <= ~o_tach[f]; // no supply, line not valid
            else if (div == 2'h0)
                o_tach[f] <= ~o_tach[f]; // rotating fan
        end
    end
endmodule // fan_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
// ==========
// self-checking bench for fan control
module testbench;
    import fan_ctrl_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic [7:0] i_cmd_type = 8'h00;
    logic [7:0] i_cmd_len = 8'h00;
    logic [3:0][7:0] i_cmd_data = '0;
    logic [3:0] i_pwr_we = 4'h0;
    logic [3:0][7:0] i_pwr_val = '0;
    logic i_boot_store = 1'b0;
    logic [3:0] i_tach;
    logic o_rsp_valid;
    logic [7:0] o_rsp_type;
    logic [7:0] o_rsp_len;
    logic [4:0][7:0] o_rsp_data;
    logic [3:0] o_fan_on;
    logic [3:0] o_tach_pulse;
    logic [3:0][7:0] o_fan_power;
    logic [3:0] o_fs_mask;
    logic [3:0][7:0] o_glitch;
    logic [3:0][7:0] o_boot_glitch;
    logic got; // reply seen
    int n_errors = 0;
    int cmp_count = 0;
    int on2 = 0; // fan 3 on cycles
    int p1 = 0; // fan 2 tach pulses
    int p2 = 0; // fan 3 tach pulses
    always #4 i_clk = ~i_clk;
    fan_failsafe_tach_control #(.STEP_CYC(4), .TICK_CYC(20)) u_fan_failsafe_tach_control (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
        .i_cmd_type(i_cmd_type), .i_cmd_len(i_cmd_len), .i_cmd_data(i_cmd_data),
        .i_pwr_we(i_pwr_we), .i_pwr_val(i_pwr_val), .i_boot_store(i_boot_store),
        .i_tach(i_tach), .o_rsp_valid(o_rsp_valid), .o_rsp_type(o_rsp_type),
        .o_rsp_len(o_rsp_len), .o_rsp_data(o_rsp_data), .o_fan_on(o_fan_on),
        .o_tach_pulse(o_tach_pulse), .o_fan_power(o_fan_power), .o_fs_mask(o_fs_mask),
        .o_glitch(o_glitch), .o_boot_glitch(o_boot_glitch));
    fan_model u_fan_model (.i_clk(i_clk), .i_fan_on(o_fan_on), .o_tach(i_tach));
    // ==========
    // shared tasks
    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one command pulse, then a bounded wait for the reply
    task automatic send(input logic [7:0] t, input logic [7:0] l, input logic [31:0] d);
        @(negedge i_clk);
        i_cmd_valid = 1'b1;
        i_cmd_type = t;
        i_cmd_len = l;
        i_cmd_data = d;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        got = 1'b0;
        for (int k = 0; k < 3 && got !== 1'b1; k++)
        begin
            if (o_rsp_valid === 1'b1)
                got = 1'b1;
            else
                @(negedge i_clk);
        end
    endtask
    task automatic wpwr(input int f, input logic [7:0] v);
        @(negedge i_clk);
        i_pwr_we[f] = 1'b1;
        i_pwr_val[f] = v;
        @(negedge i_clk);
        i_pwr_we = 4'h0;
    endtask
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog against a hung run
    initial
    begin
        repeat (10000) @(posedge i_clk);
        n_errors++;
        give_verdict();
    end
    // ==========
    // test sequence
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        cmp("glitch reset", 40'h01010101, o_glitch);
        send(CMD_FAILSAFE, 8'h03, 32'h0000020F);
        cmp("bad length reply", 40'h0, got);
        cmp("bad length mask", 40'h0, o_fs_mask);
        send(8'h1C, LEN_QUERY, 32'h0);
        cmp("unknown code reply", 40'h0, got);
        for (int f = 0; f < 4; f++)
            wpwr(f, 8'h32);
        send(CMD_FAILSAFE, LEN_FAILSAFE, 32'h0000020F);
        cmp("arm reply", 40'h15900, {got, o_rsp_type, o_rsp_len});
        cmp("mask", 40'hF, o_fs_mask);
        for (int n = 0; n < 10; n++)
        begin
            wpwr(0, 8'h32);
            repeat (8) @(negedge i_clk);
        end
        cmp("kept power", 40'h32, o_fan_power[0]);
        cmp("forced power", 40'h646464, o_fan_power[3:1]);
        send(CMD_QUERY, LEN_QUERY, 32'h0);
        cmp("query head", 40'h15B05, {got, o_rsp_type, o_rsp_len});
        cmp("query data", 40'h0F64646432, o_rsp_data);
        send(CMD_FAILSAFE, LEN_FAILSAFE, 32'h00000200);
        cmp("disarm", 40'h0, o_fs_mask);
        send(CMD_GLITCH, LEN_GLITCH, 32'h09280503);
        cmp("glitch reply", 40'h15A00, {got, o_rsp_type, o_rsp_len});
        cmp("glitch set", 40'h09280503, o_glitch);
        cmp("boot before", 40'h01010101, o_boot_glitch);
        @(negedge i_clk);
        i_boot_store = 1'b1;
        @(negedge i_clk);
        i_boot_store = 1'b0;
        @(negedge i_clk);
        cmp("boot copy", 40'h09280503, o_boot_glitch);
        wpwr(2, 8'h1E);
        wpwr(1, 8'h64);
        repeat (800) @(negedge i_clk);
        for (int c = 0; c < 400; c++)
        begin
            @(negedge i_clk);
            on2 += (o_fan_on[2] === 1'b1);
            p1 += (o_tach_pulse[1] === 1'b1);
            p2 += (o_tach_pulse[2] === 1'b1);
        end
        cmp("pwm on cycles", 40'd120, on2);
        cmp("blanked tach", 40'd0, p2);
        cmp("open tach", 40'h1, p1 > 0);
        give_verdict();
    end
endmodule // testbench
